// >>> dfc_consts.svh
// Summary of operation
// - data-lane high-level flag, bit 1, shows any lane above 1.7 V.
// - data-lane low-level flag, bit 0, shows any lane below 0.7 V.
// - two-bit capture clock delay: 350, 590, 800, 925 ps; resets to 00.
// - capture clock delay acts only on second silicon revision.
// - FIFO reset puts write pointer ahead of read by offset; resets to 4.
// - warning 1, bit 7, while pointers are within one entry.
// - warning 2, bit 6, while pointers are within two entries.
// - host writes 1 to bit 1 to request pointer realignment; resets 0.
// - acknowledge, bit 2, set once a serial-started FIFO reset aligned pointers.
// - FIFO fill reported as 8-bit thermometer code.
// - bit 7 bypasses premodulator, bit 5 bypasses NCO; both reset to 1.
// - bit 6 bypasses inverse sinc filter; resets to 1.
// - bit 2 bypasses phase compensation and dc offset; resets to 1.
// - bit 3 halves the NCO signal into the modulator; resets to 0.
// - bit 1 picks low-side image when 1, high-side when 0; resets 0.
// - bit 0 drops Q input, stops Q clocks, feeds I to both converters.
`ifndef DFC_CONSTS_SVH
`define DFC_CONSTS_SVH
`define DFC_ADDR_RX_STATUS  7'h15
`define DFC_ADDR_DATA_CLOCK_DELAY_SELECT  7'h16
`define DFC_ADDR_FIFO_PRE   7'h17
`define DFC_ADDR_FIFO_STAT  7'h18
`define DFC_ADDR_FIFO_LVL   7'h19
`define DFC_ADDR_DATAPATH   7'h1b
`define DFC_BIT_LANE_HI     1
`define DFC_BIT_LANE_LO     0
`define DFC_BIT_WARN1       7
`define DFC_BIT_WARN2       6
`define DFC_BIT_ALIGN_ACK   2
`define DFC_BIT_ALIGN_REQ   1
`define DFC_BIT_PREMOD      7
`define DFC_BIT_INV_SINC    6
`define DFC_BIT_NCO         5
`define DFC_BIT_NCO_GAIN    3
`define DFC_BIT_PHASE_DC    2
`define DFC_BIT_SIDEBAND    1
`define DFC_BIT_DUP_I       0
`define DFC_RST_DATA_CLOCK_DELAY_SELECT   2'h0
`define DFC_RST_FIFO_OFFS   3'h4
`define DFC_RST_DATAPATH    8'he4
`define DFC_MASK_DATAPATH   8'hef
`define DFC_DELAY_REV       4'h2
`endif

// >>> dfc_pkg.sv
package dfc_pkg;
  typedef logic [6:0]  dfc_addr_t;
  typedef logic [7:0]  dfc_byte_t;
  typedef logic [2:0]  dfc_ptr_t;
  typedef logic [13:0] dfc_sample_t;
  typedef enum logic [1:0] {
    DFC_SPI_IDLE,
    DFC_SPI_ADDR,
    DFC_SPI_DATA,
    DFC_SPI_DONE
  } dfc_spi_state_t;
endpackage : dfc_pkg

// >>> dfc_sync2.sv
`timescale 1ns/1ps
module dfc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : dfc_sync2

// >>> dfc_fifo_track.sv
`timescale 1ns/1ps
`include "dfc_consts.svh"
module dfc_fifo_track (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_wr_adv,
  input  wire logic              i_rd_adv,
  input  wire logic              i_align,
  input  wire dfc_pkg::dfc_ptr_t i_offset,
  output dfc_pkg::dfc_ptr_t      o_wr_ptr,
  output dfc_pkg::dfc_ptr_t      o_rd_ptr,
  output logic                   o_warn1,
  output logic                   o_warn2,
  output dfc_pkg::dfc_byte_t     o_level,
  output logic                   o_aligned
);
  import dfc_pkg::*;

  dfc_ptr_t rd_next;
  dfc_ptr_t diff;

  function automatic dfc_byte_t therm(input dfc_ptr_t d);
    dfc_byte_t t;
    t = '0;
    for (int k = 0; k < 8; k++) begin
      t[k] = (k < int'(d));
    end
    return t;
  endfunction : therm

  assign rd_next = o_rd_ptr + dfc_ptr_t'(i_rd_adv);
  assign diff    = o_wr_ptr - o_rd_ptr;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_ptr <= '0;
      o_wr_ptr <= `DFC_RST_FIFO_OFFS;
    end else begin
      o_rd_ptr <= rd_next;
      if (i_align) begin
        o_wr_ptr <= rd_next + i_offset;
      end else begin
        o_wr_ptr <= o_wr_ptr + dfc_ptr_t'(i_wr_adv);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_warn1   <= 1'b0;
      o_warn2   <= 1'b0;
      o_level   <= '0;
      o_aligned <= 1'b0;
    end else begin
      o_warn1   <= (diff <= 3'h1) || (diff == 3'h7);
      o_warn2   <= (diff <= 3'h2) || (diff >= 3'h6);
      o_level   <= therm(diff);
      o_aligned <= i_align;
    end
  end

  a_align_offset: assert property (@(posedge i_clk) disable iff (i_reset)
    i_align |=> (o_wr_ptr - o_rd_ptr) == $past(i_offset))
    else $error("pointer gap after align differs from offset");
  a_warn_one: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_wr_ptr == o_rd_ptr) |=> o_warn1 && o_warn2)
    else $error("warning flags missing with equal pointers");
  a_warn_two: assert property (@(posedge i_clk) disable iff (i_reset)
    (diff == 3'h2) |=> !o_warn1 && o_warn2)
    else $error("warning flags wrong at distance two");
  a_level_code: assert property (@(posedge i_clk) disable iff (i_reset)
    (diff == 3'h4) |=> o_level == 8'h0f)
    else $error("fill level code wrong at depth four");
endmodule : dfc_fifo_track

// >>> dfc_regs.sv
`timescale 1ns/1ps
`include "dfc_consts.svh"
module dfc_regs #(
  parameter logic [3:0] SILICON_REV = 4'h2
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_spi_cs_n,
  input  wire logic                 i_spi_sclk,
  input  wire logic                 i_spi_sdi,
  output logic                      o_spi_sdo,
  output logic                      o_spi_sdo_oe,
  input  wire logic                 i_lane_over_hi,
  input  wire logic                 i_lane_under_lo,
  input  wire logic                 i_fifo_wr_adv,
  input  wire logic                 i_fifo_rd_adv,
  input  wire logic                 i_ext_fifo_reset,
  output dfc_pkg::dfc_ptr_t         o_fifo_wr_ptr,
  output dfc_pkg::dfc_ptr_t         o_fifo_rd_ptr,
  output logic [1:0]                o_data_clock_delay_sel,
  output logic                      o_bypass_premod,
  output logic                      o_bypass_inv_sinc,
  output logic                      o_bypass_nco,
  output logic                      o_nco_half_gain,
  output logic                      o_bypass_phase_dc,
  output logic                      o_low_sideband,
  output logic                      o_duplicate_inphase_stream,
  output logic                      o_q_clock_en,
  input  wire dfc_pkg::dfc_sample_t i_i_sample,
  input  wire dfc_pkg::dfc_sample_t i_q_sample,
  output dfc_pkg::dfc_sample_t      o_i_sample,
  output dfc_pkg::dfc_sample_t      o_q_sample,
  input  wire logic [15:0]          i_nco_sample,
  output logic [15:0]               o_nco_sample
);
  import dfc_pkg::*;

  // pins from outside the clock domain
  logic [4:0]     pin_s;
  logic           s_cs_n;
  logic           s_sclk;
  logic           s_sdi;
  logic           lane_hi_s;
  logic           lane_lo_s;
  logic           sclk_q;
  logic           rise;
  logic           fall;

  dfc_spi_state_t state_q;
  logic [2:0]     cnt_q;
  dfc_byte_t      shift_q;
  logic           rw_q;
  dfc_addr_t      addr_q;
  dfc_byte_t      rd_shift_q;
  dfc_byte_t      rd_mux;
  logic           wr_stb_q;
  dfc_addr_t      wr_addr_q;
  dfc_byte_t      wr_data_q;

  logic [1:0]     dci_q;
  dfc_ptr_t       offset_q;
  dfc_byte_t      dp_q;
  logic           align_req_q;
  logic           align_ack_q;
  logic           soft_go_q;
  logic           req_write;
  logic           fifo_aligned;
  logic           warn1;
  logic           warn2;
  dfc_byte_t      level;

  // select enters inverted: flops reset to deselected, so no false frame after reset
  dfc_sync2 #(
    .W (5)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async ({~i_spi_cs_n, i_spi_sclk, i_spi_sdi, i_lane_over_hi, i_lane_under_lo}),
    .o_sync  (pin_s)
  );

  assign s_cs_n    = !pin_s[4];
  assign s_sclk    = pin_s[3];
  assign s_sdi     = pin_s[2];
  assign lane_hi_s = pin_s[1];
  assign lane_lo_s = pin_s[0];
  assign rise      = s_sclk && !sclk_q;
  assign fall      = !s_sclk && sclk_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= s_sclk;
    end
  end

  // serial frame: r/w bit, 7 address bits, 8 data bits, msb first
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= DFC_SPI_IDLE;
      cnt_q   <= '0;
      shift_q <= '0;
      rw_q    <= 1'b0;
      addr_q  <= '0;
    end else if (s_cs_n) begin
      state_q <= DFC_SPI_IDLE;
      cnt_q   <= '0;
    end else begin
      unique case (state_q)
        DFC_SPI_IDLE: begin
          state_q <= DFC_SPI_ADDR;
          cnt_q   <= '0;
        end
        DFC_SPI_ADDR: begin
          if (rise) begin
            shift_q <= {shift_q[6:0], s_sdi};
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              rw_q    <= shift_q[6];
              addr_q  <= {shift_q[5:0], s_sdi};
              state_q <= DFC_SPI_DATA;
            end
          end
        end
        DFC_SPI_DATA: begin
          if (rise) begin
            shift_q <= {shift_q[6:0], s_sdi};
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              state_q <= DFC_SPI_DONE;
            end
          end
        end
        DFC_SPI_DONE: begin
          state_q <= DFC_SPI_DONE;
        end
      endcase
    end
  end

  // write strobe one cycle after the last data bit is taken
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_stb_q  <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      wr_stb_q  <= !s_cs_n && rise && (state_q == DFC_SPI_DATA) &&
                   (cnt_q == 3'h7) && !rw_q;
      wr_addr_q <= addr_q;
      wr_data_q <= {shift_q[6:0], s_sdi};
    end
  end

  // read data: cleared on the last address bit, loaded in the data phase until the first rise except on a fall, shifted on later falling edges
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rd_shift_q <= '0;
    end else if (!s_cs_n && rise && state_q == DFC_SPI_ADDR && cnt_q == 3'h7) begin
      rd_shift_q <= '0;
    end else if (state_q == DFC_SPI_DATA && rw_q && cnt_q == 3'h0 && !fall) begin
      rd_shift_q <= rd_mux;
    end else if (fall && state_q == DFC_SPI_DATA && cnt_q != 3'h0) begin
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
    end
  end

  assign o_spi_sdo    = rd_shift_q[7];
  assign o_spi_sdo_oe = !s_cs_n && rw_q &&
                        (state_q == DFC_SPI_DATA || state_q == DFC_SPI_DONE);

  // reserved and unmapped bits read as zero
  always_comb begin
    rd_mux = '0;
    unique case (addr_q)
      `DFC_ADDR_RX_STATUS: begin
        rd_mux[`DFC_BIT_LANE_HI] = lane_hi_s;
        rd_mux[`DFC_BIT_LANE_LO] = lane_lo_s;
      end
      `DFC_ADDR_DATA_CLOCK_DELAY_SELECT: rd_mux[1:0] = dci_q;
      `DFC_ADDR_FIFO_PRE:  rd_mux[2:0] = offset_q;
      `DFC_ADDR_FIFO_STAT: begin
        rd_mux[`DFC_BIT_WARN1]     = warn1;
        rd_mux[`DFC_BIT_WARN2]     = warn2;
        rd_mux[`DFC_BIT_ALIGN_ACK] = align_ack_q;
        rd_mux[`DFC_BIT_ALIGN_REQ] = align_req_q;
      end
      `DFC_ADDR_FIFO_LVL:  rd_mux = level;
      `DFC_ADDR_DATAPATH:  rd_mux = dp_q;
      default:             rd_mux = '0;
    endcase
  end

  // writes to status and level addresses fall through untouched
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dci_q    <= `DFC_RST_DATA_CLOCK_DELAY_SELECT;
      offset_q <= `DFC_RST_FIFO_OFFS;
      dp_q     <= `DFC_RST_DATAPATH;
    end else if (wr_stb_q) begin
      unique case (wr_addr_q)
        `DFC_ADDR_DATA_CLOCK_DELAY_SELECT: dci_q    <= wr_data_q[1:0];
        `DFC_ADDR_FIFO_PRE:  offset_q <= wr_data_q[2:0];
        `DFC_ADDR_DATAPATH:  dp_q     <= wr_data_q & `DFC_MASK_DATAPATH;
        default: ;
      endcase
    end
  end

  assign req_write = wr_stb_q && wr_addr_q == `DFC_ADDR_FIFO_STAT &&
                     wr_data_q[`DFC_BIT_ALIGN_REQ];

  // request clears itself once the pointers are realigned
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      align_req_q <= 1'b0;
      soft_go_q   <= 1'b0;
    end else begin
      soft_go_q <= req_write;
      if (req_write) begin
        align_req_q <= 1'b1;
      end else if (fifo_aligned) begin
        align_req_q <= 1'b0;
      end
    end
  end

  // a fresh request clears the old ack; completion wins on a tie
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      align_ack_q <= 1'b0;
    end else if (fifo_aligned && align_req_q) begin
      align_ack_q <= 1'b1;
    end else if (req_write) begin
      align_ack_q <= 1'b0;
    end
  end

  dfc_fifo_track u_track (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_adv  (i_fifo_wr_adv),
    .i_rd_adv  (i_fifo_rd_adv),
    .i_align   (soft_go_q || i_ext_fifo_reset),
    .i_offset  (offset_q),
    .o_wr_ptr  (o_fifo_wr_ptr),
    .o_rd_ptr  (o_fifo_rd_ptr),
    .o_warn1   (warn1),
    .o_warn2   (warn2),
    .o_level   (level),
    .o_aligned (fifo_aligned)
  );

  // older silicon keeps the shortest delay whatever is written
  assign o_data_clock_delay_sel = (SILICON_REV == `DFC_DELAY_REV) ? dci_q
                                : `DFC_RST_DATA_CLOCK_DELAY_SELECT;

  assign o_bypass_premod            = dp_q[`DFC_BIT_PREMOD];
  assign o_bypass_nco               = dp_q[`DFC_BIT_NCO];
  assign o_bypass_inv_sinc          = dp_q[`DFC_BIT_INV_SINC];
  assign o_bypass_phase_dc          = dp_q[`DFC_BIT_PHASE_DC];
  assign o_nco_half_gain            = dp_q[`DFC_BIT_NCO_GAIN];
  assign o_low_sideband             = dp_q[`DFC_BIT_SIDEBAND];
  assign o_duplicate_inphase_stream = dp_q[`DFC_BIT_DUP_I];
  assign o_q_clock_en               = !dp_q[`DFC_BIT_DUP_I];

  // sample stage: Q input is dropped while duplicating I
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_i_sample <= '0;
      o_q_sample <= '0;
    end else begin
      o_i_sample <= i_i_sample;
      o_q_sample <= dp_q[`DFC_BIT_DUP_I] ? i_i_sample : i_q_sample;
    end
  end

  // arithmetic halving keeps the sign of the nco word
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_nco_sample <= '0;
    end else if (dp_q[`DFC_BIT_NCO_GAIN]) begin
      o_nco_sample <= {i_nco_sample[15], i_nco_sample[15:1]};
    end else begin
      o_nco_sample <= i_nco_sample;
    end
  end

  a_dp_reset_val: assert property (@(posedge i_clk)
    $past(i_reset) && !i_reset |-> o_bypass_premod && o_bypass_nco &&
      o_bypass_inv_sinc && o_bypass_phase_dc && !o_nco_half_gain &&
      !o_low_sideband && !o_duplicate_inphase_stream)
    else $error("datapath bits not at reset values");
  a_sinc_write: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_stb_q && wr_addr_q == `DFC_ADDR_DATAPATH |=>
      o_bypass_inv_sinc == $past(wr_data_q[6]) &&
      o_bypass_phase_dc == $past(wr_data_q[2]))
    else $error("bypass bits did not follow the write");
  a_premod_write: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_stb_q && wr_addr_q == `DFC_ADDR_DATAPATH |=>
      o_bypass_premod == $past(wr_data_q[7]) && o_bypass_nco == $past(wr_data_q[5]))
    else $error("premodulator or nco bypass did not follow the write");
  a_sideband_wr: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_stb_q && wr_addr_q == `DFC_ADDR_DATAPATH |=>
      o_low_sideband == $past(wr_data_q[1]))
    else $error("sideband select did not follow the write");
  a_nco_scale: assert property (@(posedge i_clk) disable iff (i_reset)
    o_nco_half_gain ##1 $stable(o_nco_half_gain) |->
      o_nco_sample == {$past(i_nco_sample[15]), $past(i_nco_sample[15:1])})
    else $error("nco word not halved");
  a_dup_stream: assert property (@(posedge i_clk) disable iff (i_reset)
    o_duplicate_inphase_stream |=> o_q_sample == $past(i_i_sample) ||
      !$past(o_duplicate_inphase_stream, 1))
    else $error("Q converter not fed from I stream");
  a_delay_gate: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_stb_q && wr_addr_q == `DFC_ADDR_DATA_CLOCK_DELAY_SELECT |=>
      o_data_clock_delay_sel == ((SILICON_REV == `DFC_DELAY_REV) ?
        $past(wr_data_q[1:0]) : 2'h0))
    else $error("capture delay select wrong after write");
  a_offset_write: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_stb_q && wr_addr_q == `DFC_ADDR_FIFO_PRE |=> offset_q == $past(wr_data_q[2:0]))
    else $error("pointer offset did not follow the write");
  a_align_done: assert property (@(posedge i_clk) disable iff (i_reset)
    req_write |=> align_req_q ##2 !align_req_q && align_ack_q)
    else $error("soft align not completed and acknowledged");
  a_ack_clear: assert property (@(posedge i_clk) disable iff (i_reset)
    req_write && !(fifo_aligned && align_req_q) |=> !align_ack_q)
    else $error("new align request did not clear the acknowledge");
  a_ro_write: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_stb_q && wr_addr_q == `DFC_ADDR_FIFO_LVL |=>
      $stable(dci_q) && $stable(offset_q) && $stable(dp_q))
    else $error("write to level register changed a setting");
  a_rsvd_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    addr_q == `DFC_ADDR_FIFO_PRE |-> rd_mux[7:3] == 5'h00)
    else $error("reserved bits read non-zero");
  a_lane_flag: assert property (@(posedge i_clk) disable iff (i_reset)
    addr_q == `DFC_ADDR_RX_STATUS |-> rd_mux[1:0] == {lane_hi_s, lane_lo_s})
    else $error("lane level flags not reported");

  c_soft_align: cover property (@(posedge i_clk) disable iff (i_reset)
    req_write ##3 align_ack_q);
  c_read_frame: cover property (@(posedge i_clk) disable iff (i_reset)
    o_spi_sdo_oe ##1 s_cs_n);
  c_dup_mode: cover property (@(posedge i_clk) disable iff (i_reset)
    o_duplicate_inphase_stream && !o_q_clock_en);
  c_ext_align: cover property (@(posedge i_clk) disable iff (i_reset)
    i_ext_fifo_reset ##1 fifo_aligned);
endmodule : dfc_regs

// >>> dfc_host_model.sv
`timescale 1ns/1ps
module dfc_host_model (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_sdi
);
  import dfc_pkg::*;
  // each sclk phase must span at least 3 system clocks to survive the synchroniser
  localparam int HALF = 5;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi  = 1'b1;
  end
  task automatic xfer(input logic is_read, input dfc_addr_t addr, input dfc_byte_t wdata,
                      output dfc_byte_t rdata);
    logic [15:0] frame;
    frame = {is_read, addr, wdata};
    rdata = '0;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (HALF) @(negedge i_clk);
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b0;
      o_sdi  = frame[i];
      repeat (HALF) @(negedge i_clk);
      o_sclk = 1'b1;
      if (i < 8) begin
        rdata[i] = i_sdo;
      end
      repeat (HALF) @(negedge i_clk);
    end
    o_sclk = 1'b0;
    // released data line shows the inverse so a stale bit is never mistaken for data
    o_sdi  = ~o_sdi;
    repeat (HALF) @(negedge i_clk);
    o_cs_n = 1'b1;
    repeat (HALF + 2) @(negedge i_clk);
  endtask : xfer
endmodule : dfc_host_model

// >>> dfc_regs_bench.sv
`timescale 1ns/1ps
`include "dfc_consts.svh"
module dfc_regs_bench;
  import dfc_pkg::*;
  logic        i_clk, i_reset, i_spi_cs_n, i_spi_sclk, i_spi_sdi;
  logic        i_lane_over_hi, i_lane_under_lo, i_fifo_wr_adv, i_fifo_rd_adv, i_ext_fifo_reset;
  logic        o_spi_sdo, o_spi_sdo_oe, o_bypass_premod, o_bypass_inv_sinc, o_bypass_nco;
  logic        o_nco_half_gain, o_bypass_phase_dc, o_low_sideband, o_duplicate_inphase_stream;
  logic        o_q_clock_en;
  logic [1:0]  o_data_clock_delay_sel, delay_rev1;
  dfc_ptr_t    o_fifo_wr_ptr, o_fifo_rd_ptr;
  dfc_sample_t i_i_sample, i_q_sample, o_i_sample, o_q_sample;
  logic [15:0] i_nco_sample, o_nco_sample;
  int          error_cnt = 0;
  int          n_checks = 0;

  dfc_regs #(.SILICON_REV(4'h2)) dut_u (.i_clk, .i_reset, .i_spi_cs_n, .i_spi_sclk, .i_spi_sdi,
    .o_spi_sdo, .o_spi_sdo_oe, .i_lane_over_hi, .i_lane_under_lo, .i_fifo_wr_adv,
    .i_fifo_rd_adv, .i_ext_fifo_reset, .o_fifo_wr_ptr, .o_fifo_rd_ptr, .o_data_clock_delay_sel,
    .o_bypass_premod, .o_bypass_inv_sinc, .o_bypass_nco, .o_nco_half_gain, .o_bypass_phase_dc,
    .o_low_sideband, .o_duplicate_inphase_stream, .o_q_clock_en, .i_i_sample, .i_q_sample,
    .o_i_sample, .o_q_sample, .i_nco_sample, .o_nco_sample);
  // older silicon shares the serial pins; only its delay output is watched
  dfc_regs #(.SILICON_REV(4'h1)) dut_rev1_u (.i_clk, .i_reset, .i_spi_cs_n, .i_spi_sclk,
    .i_spi_sdi, .o_spi_sdo(), .o_spi_sdo_oe(), .i_lane_over_hi, .i_lane_under_lo,
    .i_fifo_wr_adv, .i_fifo_rd_adv, .i_ext_fifo_reset, .o_fifo_wr_ptr(), .o_fifo_rd_ptr(),
    .o_data_clock_delay_sel(delay_rev1), .o_bypass_premod(), .o_bypass_inv_sinc(),
    .o_bypass_nco(), .o_nco_half_gain(), .o_bypass_phase_dc(), .o_low_sideband(),
    .o_duplicate_inphase_stream(), .o_q_clock_en(), .i_i_sample, .i_q_sample, .o_i_sample(),
    .o_q_sample(), .i_nco_sample, .o_nco_sample());
  // a disabled data-out pin shows the inverse, so a missing enable spoils the read
  dfc_host_model host_u (.i_clk, .i_sdo(o_spi_sdo_oe ? o_spi_sdo : !o_spi_sdo),
    .o_cs_n(i_spi_cs_n), .o_sclk(i_spi_sclk), .o_sdi(i_spi_sdi));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input dfc_addr_t a, input dfc_byte_t d);
    dfc_byte_t unused;
    host_u.xfer(1'b0, a, d, unused);
  endtask : wr_reg

  task automatic rd_chk(input dfc_addr_t a, input dfc_byte_t exp);
    dfc_byte_t v;
    host_u.xfer(1'b1, a, 8'h00, v);
    chk(16'(v), 16'(exp));
  endtask : rd_chk

  function automatic dfc_byte_t dp_out();
    return {o_bypass_premod, o_bypass_inv_sinc, o_bypass_nco, 1'b0, o_nco_half_gain,
            o_bypass_phase_dc, o_low_sideband, o_duplicate_inphase_stream};
  endfunction : dp_out

  task automatic pulse(ref logic s);
    @(negedge i_clk);
    s = 1'b1;
    @(negedge i_clk);
    s = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask : pulse

  task automatic t_reset_values();
    chk(16'(o_fifo_wr_ptr), 16'h4);
    chk(16'(o_fifo_rd_ptr), 16'h0);
    chk(16'(dp_out()), 16'he4);
    chk(16'(o_q_clock_en), 16'h1);
    rd_chk(`DFC_ADDR_DATA_CLOCK_DELAY_SELECT, 8'h00);
    rd_chk(`DFC_ADDR_FIFO_PRE, 8'h04);
    rd_chk(`DFC_ADDR_FIFO_STAT, 8'h00);
    rd_chk(`DFC_ADDR_FIFO_LVL, 8'h0f);
    rd_chk(`DFC_ADDR_DATAPATH, 8'he4);
  endtask : t_reset_values

  task automatic t_delay();
    for (int d = 0; d < 4; d++) begin
      // reserved bits written high must not stick
      wr_reg(`DFC_ADDR_DATA_CLOCK_DELAY_SELECT, 8'hfc | 8'(d));
      chk(16'(o_data_clock_delay_sel), 16'(d));
      chk(16'(delay_rev1), 16'h0);
      rd_chk(`DFC_ADDR_DATA_CLOCK_DELAY_SELECT, 8'(d));
    end
  endtask : t_delay

  task automatic t_datapath();
    dfc_byte_t val;
    for (int b = 0; b < 8; b++) begin
      val = 8'h01 << b;
      wr_reg(`DFC_ADDR_DATAPATH, val);
      chk(16'(dp_out()), 16'(val & 8'hef));
      chk(16'(o_q_clock_en), 16'(!val[0]));
      chk(16'(o_i_sample), 16'h1234);
      chk(16'(o_q_sample), val[0] ? 16'h1234 : 16'h0abc);
      chk(o_nco_sample, val[3] ? 16'hc001 : 16'h8002);
      rd_chk(`DFC_ADDR_DATAPATH, val & 8'hef);
    end
  endtask : t_datapath

  task automatic t_lane_flags();
    for (int k = 0; k < 4; k++) begin
      @(negedge i_clk);
      {i_lane_over_hi, i_lane_under_lo} = 2'(k);
      repeat (4) @(negedge i_clk);
      rd_chk(`DFC_ADDR_RX_STATUS, 8'(k));
    end
    wr_reg(`DFC_ADDR_RX_STATUS, 8'h00);
    rd_chk(`DFC_ADDR_RX_STATUS, 8'h03);
    rd_chk(7'h20, 8'h00);
    {i_lane_over_hi, i_lane_under_lo} = 2'b00;
  endtask : t_lane_flags

  task automatic t_fifo();
    logic w1;
    logic w2;
    wr_reg(`DFC_ADDR_FIFO_PRE, 8'h00);
    pulse(i_ext_fifo_reset);
    chk(16'(3'(o_fifo_wr_ptr - o_fifo_rd_ptr)), 16'h0);
    // hardware-started reset must leave the acknowledge clear
    rd_chk(`DFC_ADDR_FIFO_STAT, 8'hc0);
    wr_reg(`DFC_ADDR_FIFO_STAT, 8'h02);
    for (int k = 0; k < 8; k++) begin
      w1 = (k == 7) || (k <= 1);
      w2 = (k >= 6) || (k <= 2);
      rd_chk(`DFC_ADDR_FIFO_STAT, {w1, w2, 6'h04});
      rd_chk(`DFC_ADDR_FIFO_LVL, 8'((9'h001 << k) - 9'h001));
      pulse(i_fifo_wr_adv);
    end
    wr_reg(`DFC_ADDR_FIFO_LVL, 8'h55);
    rd_chk(`DFC_ADDR_FIFO_LVL, 8'h00);
    wr_reg(`DFC_ADDR_FIFO_PRE, 8'h07);
    pulse(i_fifo_rd_adv);
    wr_reg(`DFC_ADDR_FIFO_STAT, 8'h02);
    chk(16'(3'(o_fifo_wr_ptr - o_fifo_rd_ptr)), 16'h7);
    rd_chk(`DFC_ADDR_FIFO_STAT, 8'hc4);
    rd_chk(`DFC_ADDR_FIFO_PRE, 8'h07);
  endtask : t_fifo

  initial begin
    repeat (40000) @(posedge i_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    i_reset          = 1'b1;
    i_lane_over_hi   = 1'b0;
    i_lane_under_lo  = 1'b0;
    i_fifo_wr_adv    = 1'b0;
    i_fifo_rd_adv    = 1'b0;
    i_ext_fifo_reset = 1'b0;
    i_i_sample       = 14'h1234;
    i_q_sample       = 14'h0abc;
    i_nco_sample     = 16'h8002;
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_clk);
    t_reset_values();
    t_delay();
    t_datapath();
    t_lane_flags();
    t_fifo();
    complete_run();
  end
endmodule : dfc_regs_bench
